// ### inc/uhd_pkg.sv
/*
 constants of the usb device port core: offsets, fields, endpoint tables.
 assumes a 40 MHz reference clock.
*/
package uhd_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_MASK = 8'h08;
   localparam logic [7:0] OFF_EPCFG = 8'h10;
   localparam logic [7:0] OFF_EPSTAT = 8'h30;
   localparam logic [7:0] OFF_RAM = 8'h80;
   localparam logic [7:0] OFF_RAMDATA = 8'h84;
   localparam logic [7:0] OFF_IDENT = 8'h88;
   // arbitrary neutral identification value
   localparam logic [31:0] IDENT_VALUE = 32'h0000_0001;
   // control register fields
   localparam int CTRL_SEL_BIT = 0;
   localparam int CTRL_DETACH_BIT = 1;
   // status / mask fields
   localparam int ST_SUSP = 0;
   localparam int ST_RESUME = 1;
   localparam int ST_ENDRESET = 2;
   localparam int ST_CFGERR = 3;
   localparam int ST_EP0 = 8;
   localparam int NUM_EVENTS = 15;
   // endpoint config fields
   localparam int CFG_SIZE_LSB = 0;
   localparam int CFG_TYPE_LSB = 4;
   localparam int CFG_DIR_BIT = 6;
   localparam int CFG_BANK_LSB = 8;
   localparam int CFG_ENABLE_BIT = 12;
   localparam int CFG_STALL_BIT = 13;
   localparam int CFG_MAPPED_BIT = 31;
   localparam int NUM_EP = 7;
   localparam int RAM_BYTES = 4096;
   localparam int RAM_WORDS = RAM_BYTES / 4;
   // transfer type encodings
   typedef enum logic [1:0] {
      XT_CTRL = 2'b00,
      XT_ISO = 2'b01,
      XT_BULK = 2'b10,
      XT_INT = 2'b11
   } uhd_xfer_e;
   // control transfer phases
   typedef enum logic [1:0] {
      CP_IDLE = 2'b00,
      CP_DATA = 2'b01,
      CP_STATUS = 2'b10
   } uhd_ctl_phase_e;
   // size code n means 8 << n bytes
   localparam logic [3:0] SIZE_CODE_64 = 4'h3;
   localparam logic [3:0] SIZE_CODE_512 = 4'h6;
   localparam logic [3:0] SIZE_CODE_1024 = 4'h7;
   localparam logic [3:0] MIN_SIZE_BYTES_LOG2 = 4'h3;
   // per endpoint capability tables, index 0 is endpoint_zero
   localparam logic [1:0] EP_BANKS [NUM_EP] = '{2'h1, 2'h2, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
   localparam logic [NUM_EP-1:0] EP_HIGHBW = 7'h66;
   localparam logic [NUM_EP-1:0] EP_DMA = 7'h7E;
   // line idle time treated as suspend
   localparam int SUSPEND_US = 3000;
   localparam int CLK_MHZ = 40;
   localparam int SUSPEND_CYCLES = SUSPEND_US * CLK_MHZ;
   // single-ended zero length marking bus reset
   localparam int BUSRESET_US = 3;
   localparam int BUSRESET_CYCLES = BUSRESET_US * CLK_MHZ;
   // line state codes
   localparam logic [1:0] LS_SE0 = 2'h0;
   localparam logic [1:0] LS_J = 2'h1;
   localparam logic [1:0] LS_K = 2'h2;
   // handshake codes returned to the packet engine
   localparam logic [1:0] HS_ACK = 2'h0;
   localparam logic [1:0] HS_NAK = 2'h1;
   localparam logic [1:0] HS_STALL = 2'h2;
   localparam logic [1:0] HS_NONE = 2'h3;
   // token kinds from the packet engine
   localparam logic [1:0] TK_SETUP = 2'h0;
   localparam logic [1:0] TK_IN = 2'h1;
   localparam logic [1:0] TK_OUT = 2'h2;
endpackage

// ### logic/uhd_ep_check.sv
/*
 endpoint legality: type, size and banks against fixed capabilities.
 assumes the request comes straight from software.
*/
`timescale 1ns/1ps
module uhd_ep_check #(
   parameter int EP_INDEX = 0
) (
   // requested configuration
   input wire logic [1:0] xfer_type,
   input wire logic [3:0] size_code,
   input wire logic [1:0] banks,
   // verdict
   output logic mapped
);
   localparam logic [1:0] MAX_BANKS = uhd_pkg::EP_BANKS[EP_INDEX];
   wire is_ctrl = (xfer_type == uhd_pkg::XT_CTRL);
   wire is_iso = (xfer_type == uhd_pkg::XT_ISO);
   wire is_bulk = (xfer_type == uhd_pkg::XT_BULK);
   // size limits by transfer type
   wire size_ok = is_ctrl ? (size_code <= uhd_pkg::SIZE_CODE_64) :
                  is_bulk ? (size_code <= uhd_pkg::SIZE_CODE_512) :
                  (size_code <= uhd_pkg::SIZE_CODE_1024);
   // control wants one bank, iso two or three
   wire banks_ok = (banks != 2'h0) && (banks <= MAX_BANKS) &&
                   (!is_ctrl || banks == 2'h1) &&
                   (!is_iso || banks >= 2'h2);
   // endpoint_zero is control only, at most 64 bytes
   wire ep0_ok = (EP_INDEX != 0) || is_ctrl;
   assign mapped = size_ok && banks_ok && ep0_ok;
endmodule

// ### logic/uhd_line_monitor.sv
/*
 line monitor: suspend, resume and end of bus reset from line state.
 assumes line state is synchronous to ref_clk.
*/
`timescale 1ns/1ps
module uhd_line_monitor #(
   parameter int SUSPEND_CYCLES = uhd_pkg::SUSPEND_CYCLES,
   parameter int BUSRESET_CYCLES = uhd_pkg::BUSRESET_CYCLES
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // line
   input wire logic enable,
   input wire logic [1:0] line_state,
   input wire logic activity,
   // events, one-cycle pulses, plus the suspended level
   output logic suspend_pulse,
   output logic resume_pulse,
   output logic endreset_pulse,
   output logic suspended
);
   logic [31:0] idle_cnt;
   logic [31:0] se0_cnt;
   logic in_reset;
   wire idle = (line_state == uhd_pkg::LS_J) && !activity;
   wire se0 = (line_state == uhd_pkg::LS_SE0);
   wire hit_suspend = enable && idle && !suspended && (idle_cnt == 32'(SUSPEND_CYCLES - 1));
   wire hit_resume = enable && suspended && !idle;
   wire hit_reset = enable && se0 && (se0_cnt == 32'(BUSRESET_CYCLES - 1));
   wire end_reset = enable && in_reset && !se0;
   // counters for idle and reset duration; suspend fires once per idle spell
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         idle_cnt <= 32'h0;
         se0_cnt <= 32'h0;
         in_reset <= 1'b0;
         suspended <= 1'b0;
         suspend_pulse <= 1'b0;
         resume_pulse <= 1'b0;
         endreset_pulse <= 1'b0;
      end else begin
         idle_cnt <= (idle && enable && !suspended) ? idle_cnt + 32'h1 : 32'h0;
         se0_cnt <= (se0 && enable && !hit_reset) ? se0_cnt + 32'h1 : 32'h0;
         in_reset <= hit_reset ? 1'b1 : (end_reset ? 1'b0 : in_reset);
         suspended <= hit_suspend ? 1'b1 : (hit_resume ? 1'b0 : suspended);
         suspend_pulse <= hit_suspend;
         resume_pulse <= hit_resume;
         endreset_pulse <= end_reset;
      end
   end
endmodule

// ### logic/uhd_device_core.sv
/*
 usb device port core: ahb-lite registers, seven endpoints, endpoint_buffer_ram,
 control sequencing, handshakes, transceiver sharing and one interrupt line.
 assumes a packet engine decoding tokens and crc ahead, inputs on ref_clk.
*/
// Design decisions made here: register access over AHB-Lite and the register addresses.
//
// Notes on behaviour
// - port select bit routes shared transceiver
// - one interrupt line, controller source 23
// - packet size limits depend on type
// - iso no retry; others retry; errors detected
// - control: setup, data, opposite-direction status
// - control uses one bank; stall aborts
// - iso endpoints need two or three banks
// - endpoint handles its type's transactions
// - fixed per-endpoint banks, dma, bandwidth, size
// - 4 KB dual-port ram holds banks; here the ram has a single software port addressed by ram_ptr
// - suspend and resume raise interrupts
// - endpoint_zero control, enabled before reset end
// - status stage handled like data stage
`timescale 1ns/1ps
module uhd_device_core #(
   parameter int SUSPEND_CYCLES = uhd_pkg::SUSPEND_CYCLES,
   parameter int IRQ_SOURCE_ID = 23
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // interrupt
   output logic irq,
   // shared transceiver
   output logic xcvr_to_device,
   output logic xcvr_opmode_drive,
   output logic xcvr_suspend_n,
   input wire logic [1:0] line_state,
   input wire logic line_activity,
   // packet engine token and handshake
   input wire logic tok_valid,
   input wire logic [1:0] tok_kind,
   input wire logic [2:0] tok_ep,
   input wire logic tok_crc_err,
   output logic hs_valid,
   output logic [1:0] hs_code
);
   localparam int NE = uhd_pkg::NUM_EP;
   // registers
   logic [31:0] ctrl;
   logic [uhd_pkg::NUM_EVENTS-1:0] status;
   logic [uhd_pkg::NUM_EVENTS-1:0] mask;
   logic [13:0] epcfg [NE];
   logic [1:0] bank_fill [NE];
   logic [1:0] err_cnt [NE];
   logic [9:0] ram_ptr;
   logic [31:0] ram [uhd_pkg::RAM_WORDS];
   logic [31:0] ram_q;
   uhd_pkg::uhd_ctl_phase_e ctl_phase;
   logic ctl_dir_in;
   // ahb address phase capture
   logic dp_valid;
   logic dp_write;
   logic [7:0] dp_addr;
   wire addr_phase = hsel && hready && htrans[1];
   // per-endpoint legality check, one instance per endpoint
   logic [NE-1:0] ep_mapped;
   genvar g;
   generate
      for (g = 0; g < NE; g++) begin : gen_chk
         uhd_ep_check #(.EP_INDEX(g)) u_chk (
            .xfer_type(epcfg[g][uhd_pkg::CFG_TYPE_LSB +: 2]),
            .size_code(epcfg[g][uhd_pkg::CFG_SIZE_LSB +: 4]),
            .banks(epcfg[g][uhd_pkg::CFG_BANK_LSB +: 2]),
            .mapped(ep_mapped[g])
         );
      end
   endgenerate
   // line monitor
   logic susp_p;
   logic res_p;
   logic endrst_p;
   logic suspended;
   uhd_line_monitor #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) u_mon (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .enable(ctrl[uhd_pkg::CTRL_SEL_BIT]),
      .line_state(line_state),
      .activity(line_activity),
      .suspend_pulse(susp_p),
      .resume_pulse(res_p),
      .endreset_pulse(endrst_p),
      .suspended(suspended)
   );
   // register index decode, used for read and write alike
   function automatic logic [2:0] ep_index(input logic [7:0] a);
      ep_index = a[4:2];
   endfunction
   wire sel = ctrl[uhd_pkg::CTRL_SEL_BIT];
   wire dp_wr = dp_valid && dp_write;
   wire dp_rd = dp_valid && !dp_write;
   wire is_epcfg = (dp_addr >= uhd_pkg::OFF_EPCFG) && (dp_addr < uhd_pkg::OFF_EPCFG + 8'(4 * NE));
   wire is_epstat = (dp_addr >= uhd_pkg::OFF_EPSTAT) && (dp_addr < uhd_pkg::OFF_EPSTAT + 8'(4 * NE));
   wire [2:0] dp_ep = ep_index(dp_addr - (is_epcfg ? uhd_pkg::OFF_EPCFG : uhd_pkg::OFF_EPSTAT));
   wire rd_status = dp_rd && (dp_addr == uhd_pkg::OFF_STAT);
   // token decoding against the addressed endpoint
   wire [13:0] tcfg = epcfg[tok_ep];
   wire [1:0] ttype = tcfg[uhd_pkg::CFG_TYPE_LSB +: 2];
   wire t_ctrl = (ttype == uhd_pkg::XT_CTRL);
   wire t_iso = (ttype == uhd_pkg::XT_ISO);
   wire t_dir_in = tcfg[uhd_pkg::CFG_DIR_BIT];
   wire t_live = (tok_ep < 3'(NE)) && tcfg[uhd_pkg::CFG_ENABLE_BIT] && ep_mapped[tok_ep];
   wire t_stall = tcfg[uhd_pkg::CFG_STALL_BIT];
   wire t_in = (tok_kind == uhd_pkg::TK_IN);
   wire t_out = (tok_kind == uhd_pkg::TK_OUT);
   wire t_setup = (tok_kind == uhd_pkg::TK_SETUP);
   // stream endpoints take only their own direction; control follows its stage
   wire dir_ok = t_ctrl ? (t_setup || ctl_phase != uhd_pkg::CP_IDLE) :
                 (!t_setup && (t_in == t_dir_in));
   wire [1:0] fill = bank_fill[tok_ep];
   wire [1:0] nbank = tcfg[uhd_pkg::CFG_BANK_LSB +: 2];
   wire have_data = (fill != 2'h0);
   wire have_room = (fill < nbank);
   wire ready_now = t_in ? have_data : have_room;
   // handshake choice: iso handshakes only with a stall, errors are dropped silently
   wire [1:0] next_hs = (!t_live || tok_crc_err) ? uhd_pkg::HS_NONE :
                        (t_stall && !t_setup) ? uhd_pkg::HS_STALL :
                        !dir_ok ? uhd_pkg::HS_STALL :
                        t_iso ? uhd_pkg::HS_NONE :
                        ready_now ? uhd_pkg::HS_ACK : uhd_pkg::HS_NAK;
   wire accept = tok_valid && t_live && !tok_crc_err && dir_ok && (t_iso || t_setup || ready_now) &&
                 !(t_stall && !t_setup);
   wire [uhd_pkg::NUM_EVENTS-1:0] ev;
   assign ev[uhd_pkg::ST_SUSP] = susp_p;
   assign ev[uhd_pkg::ST_RESUME] = res_p;
   assign ev[uhd_pkg::ST_ENDRESET] = endrst_p;
   assign ev[uhd_pkg::ST_CFGERR] = endrst_p && !(epcfg[0][uhd_pkg::CFG_ENABLE_BIT] && ep_mapped[0]);
   assign ev[7:4] = 4'h0;
   generate
      for (g = 0; g < NE; g++) begin : gen_ev
         assign ev[uhd_pkg::ST_EP0 + g] = tok_valid && accept && (tok_ep == 3'(g));
      end
   endgenerate
   // read mux
   wire [31:0] ep_rd = {ep_mapped[dp_ep], 17'h0, epcfg[dp_ep]};
   wire [31:0] rd_mux = (dp_addr == uhd_pkg::OFF_CTRL) ? ctrl :
                        (dp_addr == uhd_pkg::OFF_STAT) ? 32'(status) :
                        (dp_addr == uhd_pkg::OFF_MASK) ? 32'(mask) :
                        is_epcfg ? ep_rd :
                        is_epstat ? {26'h0, err_cnt[dp_ep], 2'h0, bank_fill[dp_ep]} :
                        (dp_addr == uhd_pkg::OFF_RAM) ? {22'h0, ram_ptr} :
                        (dp_addr == uhd_pkg::OFF_RAMDATA) ? ram_q :
                        (dp_addr == uhd_pkg::OFF_IDENT) ? uhd_pkg::IDENT_VALUE : 32'h0;
   // one wait state on reads lets hrdata come from a flop; writes take none
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr <= 8'h0;
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_valid <= addr_phase;
         dp_write <= hwrite;
         dp_addr <= haddr[7:0];
         hreadyout <= !(addr_phase && !hwrite);
         hrdata <= dp_rd ? rd_mux : hrdata;
      end
   end
   // control register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctrl <= 32'h0;
      end else if (dp_wr && dp_addr == uhd_pkg::OFF_CTRL) begin
         ctrl <= {30'h0, hwdata[uhd_pkg::CTRL_DETACH_BIT], hwdata[uhd_pkg::CTRL_SEL_BIT]};
      end
   end
   // sticky status: set wins over the clear-on-read
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         status <= '0;
         mask <= '0;
      end else begin
         status <= (rd_status ? '0 : status) | ev;
         if (dp_wr && dp_addr == uhd_pkg::OFF_MASK) begin
            mask <= hwdata[uhd_pkg::NUM_EVENTS-1:0];
         end
      end
   end
   // single interrupt line towards controller source IRQ_SOURCE_ID
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((rd_status ? '0 : status) | ev) & mask);
      end
   end
   // endpoint configuration, fill levels and retry counters
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int i = 0; i < NE; i++) begin
            epcfg[i] <= 14'h0;
            bank_fill[i] <= 2'h0;
            err_cnt[i] <= 2'h0;
         end
      end else begin
         if (dp_wr && is_epcfg && dp_ep < 3'(NE)) begin
            epcfg[dp_ep] <= hwdata[13:0];
         end
         if (dp_wr && is_epstat && dp_ep < 3'(NE)) begin
            bank_fill[dp_ep] <= hwdata[1:0];
         end
         // retry counter counts corrupted packets on retried types
         if (tok_valid && tok_crc_err && tok_ep < 3'(NE) && !t_iso) begin
            err_cnt[tok_ep] <= err_cnt[tok_ep] + 2'h1;
         end
      end
   end
   // control transfer stage tracking; stall aborts the transfer
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ctl_phase <= uhd_pkg::CP_IDLE;
         ctl_dir_in <= 1'b0;
      end else if (tok_valid && t_live && t_ctrl && !tok_crc_err) begin
         unique case (ctl_phase)
            uhd_pkg::CP_IDLE: begin
               if (t_setup) begin
                  ctl_phase <= uhd_pkg::CP_DATA;
               end
            end
            uhd_pkg::CP_DATA: begin
               if (t_setup) begin
                  ctl_phase <= uhd_pkg::CP_DATA;
               end else if (t_stall) begin
                  ctl_phase <= uhd_pkg::CP_IDLE;
               end else begin
                  ctl_dir_in <= t_in;
                  ctl_phase <= uhd_pkg::CP_STATUS;
               end
            end
            uhd_pkg::CP_STATUS: begin
               // a turn of direction is the status stage and ends the transfer
               if (t_setup || t_stall || (t_in != ctl_dir_in) || t_out == ctl_dir_in) begin
                  ctl_phase <= t_setup ? uhd_pkg::CP_DATA : uhd_pkg::CP_IDLE;
               end
            end
            default: ctl_phase <= uhd_pkg::CP_IDLE;
         endcase
      end
   end
   // endpoint buffer ram: software port through a pointer window
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         ram_ptr <= 10'h0;
      end else if (dp_wr && dp_addr == uhd_pkg::OFF_RAM) begin
         ram_ptr <= hwdata[9:0];
      end else if (dp_valid && dp_addr == uhd_pkg::OFF_RAMDATA) begin
         ram_ptr <= ram_ptr + 10'h1;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (dp_wr && dp_addr == uhd_pkg::OFF_RAMDATA) begin
         ram[ram_ptr] <= hwdata;
      end
      ram_q <= ram[ram_ptr];
   end
   // handshake and transceiver ownership
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         hs_valid <= 1'b0;
         hs_code <= uhd_pkg::HS_NONE;
         xcvr_to_device <= 1'b0;
         xcvr_opmode_drive <= 1'b0;
         xcvr_suspend_n <= 1'b1;
      end else begin
         hs_valid <= sel && tok_valid && next_hs != uhd_pkg::HS_NONE;
         hs_code <= sel && tok_valid ? next_hs : uhd_pkg::HS_NONE;
         xcvr_to_device <= sel;
         xcvr_opmode_drive <= sel && !ctrl[uhd_pkg::CTRL_DETACH_BIT];
         xcvr_suspend_n <= !(sel && suspended);
      end
   end
endmodule

// ### bench/uhd_device_core_props.sv
/*
 checker for uhd_device_core: ownership, handshakes, suspend, irq.
 assumes it is bound to the core and sees only its ports.
*/
`timescale 1ns/1ps
module uhd_device_core_props #(
   parameter int SUSPEND_CYCLES = 50
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // bus and interrupt
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic irq,
   // transceiver
   input wire logic xcvr_to_device,
   input wire logic xcvr_opmode_drive,
   input wire logic xcvr_suspend_n,
   input wire logic [1:0] line_state,
   input wire logic line_activity,
   // tokens and handshakes
   input wire logic tok_valid,
   input wire logic [2:0] tok_ep,
   input wire logic tok_crc_err,
   input wire logic hs_valid,
   input wire logic [1:0] hs_code
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   int idle_cnt;
   wire line_quiet = xcvr_to_device && !line_activity && line_state == uhd_pkg::LS_J;
   wire bus_req = hsel && htrans[1];
   // idle counter saturates so a long suspend cannot wrap it
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !line_quiet) begin
         idle_cnt <= 0;
      end else if (idle_cnt < SUSPEND_CYCLES + 16) begin
         idle_cnt <= idle_cnt + 1;
      end
   end
   // tokens that must never be answered
   sequence s_bad_tok;
      tok_valid && (tok_crc_err || !xcvr_to_device || tok_ep == 3'h7);
   endsequence
   // host signalling on a suspended line
   sequence s_wake;
      !xcvr_suspend_n && line_activity && line_state == uhd_pkg::LS_K;
   endsequence
   AST_DESEL_DRIVE: assert property (!xcvr_to_device |-> !xcvr_opmode_drive)
      else $error("deselected port drives transceiver");
   AST_DESEL_SUSP: assert property (!xcvr_to_device |-> xcvr_suspend_n)
      else $error("deselected port suspends transceiver");
   AST_HS_CAUSE: assert property (hs_valid |-> $past(tok_valid))
      else $error("handshake without token");
   AST_HS_CODE: assert property (hs_valid |-> hs_code != uhd_pkg::HS_NONE)
      else $error("handshake carries no code");
   AST_BAD_TOK: assert property (s_bad_tok |=> !hs_valid)
      else $error("bad token answered");
   AST_SUSPEND: assert property (idle_cnt >= SUSPEND_CYCLES + 8 |-> !xcvr_suspend_n)
      else $error("idle line not suspended");
   AST_WAKE: assert property (s_wake |-> ##[1:8] xcvr_suspend_n)
      else $error("resume not seen");
   AST_IRQ_FALL: assert property ($fell(irq) |-> $past(bus_req) || $past(bus_req, 2) || $past(bus_req, 3))
      else $error("irq dropped without bus access");
endmodule
bind uhd_device_core uhd_device_core_props #(.SUSPEND_CYCLES(SUSPEND_CYCLES)) u_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .irq(irq),
   .xcvr_to_device(xcvr_to_device), .xcvr_opmode_drive(xcvr_opmode_drive),
   .xcvr_suspend_n(xcvr_suspend_n), .line_state(line_state), .line_activity(line_activity),
   .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_crc_err(tok_crc_err),
   .hs_valid(hs_valid), .hs_code(hs_code));

// ### bench/uhd_host_model.sv
/*
 host model: line state, activity and tokens toward the core.
 assumes tasks start just after a rising edge.
*/
`timescale 1ns/1ps
module uhd_host_model (
   // clock
   input wire logic ref_clk,
   // line and tokens toward the core
   output logic [1:0] line_state,
   output logic line_activity,
   output logic tok_valid,
   output logic [1:0] tok_kind,
   output logic [2:0] tok_ep,
   output logic tok_crc_err
);
   // idle j line, no token
   initial begin
      line_state = uhd_pkg::LS_J;
      line_activity = 1'b0;
      tok_valid = 1'b0;
      tok_kind = 2'h3;
      tok_ep = 3'h0;
      tok_crc_err = 1'b0;
   end
   // fields inverted after so a stale token never looks live
   task automatic send_tok(input logic [1:0] k, input logic [2:0] ep, input logic crc);
      tok_valid <= 1'b1;
      tok_kind <= k;
      tok_ep <= ep;
      tok_crc_err <= crc;
      line_activity <= 1'b1;
      @(posedge ref_clk);
      tok_valid <= 1'b0;
      tok_kind <= ~k;
      tok_ep <= ~ep;
      tok_crc_err <= ~crc;
      line_activity <= 1'b0;
   endtask
   // k state with activity wakes a suspended port
   task automatic wake();
      line_state <= uhd_pkg::LS_K;
      line_activity <= 1'b1;
      repeat (3) @(posedge ref_clk);
      line_state <= uhd_pkg::LS_J;
      line_activity <= 1'b0;
   endtask
endmodule

// ### bench/uhd_device_core_tb_top.sv
/*
 bench for uhd_device_core: endpoints, control, sharing, suspend, reset.
 assumes uhd_host_model on the line side.
*/
`timescale 1ns/1ps
module uhd_device_core_tb_top;
   localparam int SUSP = 50;
   typedef struct packed {
      logic [2:0] ep;
      logic [3:0] size;
      logic [1:0] xt;
      logic [1:0] bk;
      logic st;
      logic [1:0] kind;
      logic crc;
      logic ans;
      logic stl;
   } uhd_row_s;
   logic ref_clk, rst_n, hsel, hwrite, hreadyout, hresp, irq, line_activity;
   logic xcvr_to_device, xcvr_opmode_drive, xcvr_suspend_n, tok_valid, tok_crc_err, hs_valid;
   logic [31:0] haddr, hwdata, hrdata, cfg, rd;
   logic [1:0] htrans, line_state, tok_kind, hs_code;
   logic [2:0] hsize, tok_ep;
   uhd_row_s r;
   int error_cnt = 0;
   int cmp_count = 0;
   // ep size xt bk stall kind crc answered stalled
   uhd_row_s rows [14] = '{
      '{3'h0, 4'h4, 2'h0, 2'h1, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
      '{3'h0, 4'h3, 2'h0, 2'h2, 1'b0, 2'h0, 1'b0, 1'b0, 1'b0},
      '{3'h0, 4'h3, 2'h0, 2'h1, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0},
      '{3'h2, 4'h0, 2'h0, 2'h1, 1'b0, 2'h0, 1'b0, 1'b1, 1'b0},
      '{3'h1, 4'h6, 2'h2, 2'h2, 1'b0, 2'h2, 1'b0, 1'b1, 1'b0},
      '{3'h1, 4'h7, 2'h2, 2'h2, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0},
      '{3'h1, 4'h7, 2'h1, 2'h1, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0},
      '{3'h1, 4'h7, 2'h1, 2'h2, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0},
      '{3'h6, 4'h7, 2'h1, 2'h3, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0},
      '{3'h3, 4'h7, 2'h3, 2'h3, 1'b0, 2'h1, 1'b0, 1'b1, 1'b0},
      '{3'h1, 4'h6, 2'h2, 2'h3, 1'b0, 2'h1, 1'b0, 1'b0, 1'b0},
      '{3'h1, 4'h3, 2'h0, 2'h1, 1'b1, 2'h1, 1'b0, 1'b1, 1'b1},
      '{3'h3, 4'h6, 2'h2, 2'h3, 1'b0, 2'h2, 1'b1, 1'b0, 1'b0},
      '{3'h7, 4'h3, 2'h2, 2'h1, 1'b0, 2'h2, 1'b0, 1'b0, 1'b0}};
   logic [1:0] seq_k [6] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1};
   // free-running clock
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   uhd_device_core #(.SUSPEND_CYCLES(SUSP), .IRQ_SOURCE_ID(23)) dut (
      .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .xcvr_to_device(xcvr_to_device),
      .xcvr_opmode_drive(xcvr_opmode_drive), .xcvr_suspend_n(xcvr_suspend_n),
      .line_state(line_state), .line_activity(line_activity), .tok_valid(tok_valid),
      .tok_kind(tok_kind), .tok_ep(tok_ep), .tok_crc_err(tok_crc_err),
      .hs_valid(hs_valid), .hs_code(hs_code));
   uhd_host_model host (
      .ref_clk(ref_clk), .line_state(line_state), .line_activity(line_activity),
      .tok_valid(tok_valid), .tok_kind(tok_kind), .tok_ep(tok_ep), .tok_crc_err(tok_crc_err));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // single word transfer; only the watchdog ends a wait
   task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   // watchdog, far past the run's length
   initial begin
      #500000;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk("to_device", xcvr_to_device, 1'b0);
      chk("drive", xcvr_opmode_drive, 1'b0);
      chk("suspend_n", xcvr_suspend_n, 1'b1);
      chk("irq", irq, 1'b0);
      host.send_tok(2'h0, 3'h0, 1'b0);
      #1;
      chk("hs_deselected", hs_valid, 1'b0);
      ahb(uhd_pkg::OFF_CTRL, 1'b1, 32'h1, rd);
      ahb(uhd_pkg::OFF_MASK, 1'b1, 32'h3, rd);
      #1;
      chk("to_device", xcvr_to_device, 1'b1);
      chk("drive", xcvr_opmode_drive, 1'b1);
      ahb(uhd_pkg::OFF_CTRL, 1'b0, 32'h0, rd);
      chk("ctrl_rd", rd, 32'h1);
      // endpoint table rows
      foreach (rows[i]) begin
         r = rows[i];
         cfg = {18'h0, r.st, 1'b1, 2'h0, r.bk, 1'b0, r.kind == uhd_pkg::TK_IN, r.xt, r.size};
         ahb(uhd_pkg::OFF_EPCFG + {3'h0, r.ep, 2'h0}, 1'b1, cfg, rd);
         host.send_tok(r.kind, r.ep, r.crc);
         #1;
         chk("hs_valid", hs_valid, r.ans);
         if (r.ans) begin
            chk("hs_stall", hs_code == uhd_pkg::HS_STALL, r.stl);
         end
      end
      // control sequences on endpoint_zero
      foreach (seq_k[i]) begin
         host.send_tok(seq_k[i], 3'h0, 1'b0);
         #1;
         chk("ctl_hs", hs_valid && hs_code != uhd_pkg::HS_STALL, 1'b1);
      end
      ahb(8'hFC, 1'b0, 32'h0, rd);
      chk("unmapped_rd", rd, 32'h0);
      ahb(uhd_pkg::OFF_STAT, 1'b0, 32'h0, rd);
      // suspend, read clear, wake and mask
      repeat (SUSP + 20) @(posedge ref_clk);
      #1;
      chk("irq_suspend", irq, 1'b1);
      chk("suspend_n", xcvr_suspend_n, 1'b0);
      ahb(uhd_pkg::OFF_STAT, 1'b0, 32'h0, rd);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("irq_cleared", irq, 1'b0);
      host.wake();
      repeat (4) @(posedge ref_clk);
      #1;
      chk("irq_resume", irq, 1'b1);
      chk("suspend_n", xcvr_suspend_n, 1'b1);
      ahb(uhd_pkg::OFF_MASK, 1'b1, 32'h0, rd);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("irq_masked", irq, 1'b0);
      // hand the transceiver back to the host port
      ahb(uhd_pkg::OFF_CTRL, 1'b1, 32'h0, rd);
      @(posedge ref_clk);
      #1;
      chk("to_device", xcvr_to_device, 1'b0);
      chk("drive", xcvr_opmode_drive, 1'b0);
      host.send_tok(2'h0, 3'h0, 1'b0);
      #1;
      chk("hs_deselected", hs_valid, 1'b0);
      ahb(uhd_pkg::OFF_CTRL, 1'b1, 32'h1, rd);
      // reset in mid-run drops ownership again
      rst_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk("to_device", xcvr_to_device, 1'b0);
      chk("irq", irq, 1'b0);
      report_and_stop();
   end
endmodule
